// ---- channel_cal_config_regs.sv ----
// Channel 3 configuration and calibration registers behind an Avalon-MM slave
`default_nettype none

//****************************************************************************
// One masked 16-bit register with reset value
//****************************************************************************
module masked_reg16 #(
  parameter logic [15:0] RESET_VALUE = 16'h0000,
  parameter logic [15:0] WRITE_MASK  = 16'hFFFF
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // Write port
  input  wire logic        write_en,
  input  wire logic [15:0] write_data,
  input  wire logic [1:0]  lane_en,
  // Stored value
  output var  logic [15:0] value
);
  logic [15:0] next_value;
  logic [15:0] lane_mask;

  // Reserved bits never take a write, so they stay at zero
  always_comb begin
    lane_mask  = {{8{lane_en[1]}}, {8{lane_en[0]}}} & WRITE_MASK;
    next_value = value;
    if (write_en) begin
      next_value = (value & ~lane_mask) | (write_data & lane_mask);
    end
  end

  // Register stage
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      value <= RESET_VALUE;
    end else begin
      value <= next_value;
    end
  end
endmodule

//****************************************************************************
// Top: register bank
//****************************************************************************
module channel_cal_config_regs (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output var  logic [31:0] readdata,
  output var  logic        waitrequest,
  output var  logic [1:0]  response,
  // Channel 3 settings to the datapath
  output var  logic [9:0]  ch3_phase_delay,
  output var  logic        ch3_dc_filter_bypass,
  output var  logic [1:0]  ch3_input_select,
  output var  logic [23:0] ch3_offset_value,
  output var  logic [23:0] ch3_gain_value,
  // Channel 4 settings to the datapath
  output var  logic [9:0]  ch4_phase_delay,
  output var  logic        ch4_dc_filter_bypass,
  output var  logic [1:0]  ch4_input_select
);

  //****************************************************************************
  // Bus handshake: one wait cycle, then answer
  //****************************************************************************
  logic        busy;
  logic        next_busy;
  logic        access;
  logic [7:0]  word_index;
  logic        hit_setup3;
  logic        hit_ofs_high;
  logic        hit_ofs_low;
  logic        hit_gain_high;
  logic        hit_gain_low;
  logic        hit_setup4;
  logic        hit_any;
  logic        do_write;
  logic [15:0] read_mux;
  logic [31:0] next_readdata;
  logic [1:0]  next_response;
  logic        next_waitrequest;

  // Byte addresses: low two bits ignored, bits above the index unused
  assign word_index = {2'h0, address[7:2]};
  assign access     = (read | write) & ~busy;

  // Decoder for the six words of the set
  always_comb begin
    hit_setup3    = (word_index == chcal_pkg::IDX_CH3_SETUP);
    hit_ofs_high  = (word_index == chcal_pkg::IDX_CH3_OFS_HIGH);
    hit_ofs_low   = (word_index == chcal_pkg::IDX_CH3_OFS_LOW);
    hit_gain_high = (word_index == chcal_pkg::IDX_CH3_GAIN_HIGH);
    hit_gain_low  = (word_index == chcal_pkg::IDX_CH3_GAIN_LOW);
    hit_setup4    = (word_index == chcal_pkg::IDX_CH4_SETUP);
    hit_any       = hit_setup3 | hit_ofs_high | hit_ofs_low |
                    hit_gain_high | hit_gain_low | hit_setup4;
  end

  // Writes take effect at the edge where waitrequest is seen low
  assign do_write = write & busy;

  //****************************************************************************
  // Register storage
  //****************************************************************************
  logic [15:0] setup3;
  logic [15:0] ofs_high;
  logic [15:0] ofs_low;
  logic [15:0] gain_high;
  logic [15:0] gain_low;
  logic [15:0] setup4;

  masked_reg16 #(.RESET_VALUE(chcal_pkg::RST_SETUP), .WRITE_MASK(chcal_pkg::MASK_SETUP))
    u_setup3 (.ref_clk(ref_clk), .srst(srst), .write_en(do_write & hit_setup3),
              .write_data(writedata[15:0]), .lane_en(byteenable[1:0]), .value(setup3));
  masked_reg16 #(.RESET_VALUE(chcal_pkg::RST_OFS_HIGH), .WRITE_MASK(chcal_pkg::MASK_FULL))
    u_ofs_high (.ref_clk(ref_clk), .srst(srst), .write_en(do_write & hit_ofs_high),
                .write_data(writedata[15:0]), .lane_en(byteenable[1:0]), .value(ofs_high));
  masked_reg16 #(.RESET_VALUE(chcal_pkg::RST_OFS_LOW), .WRITE_MASK(chcal_pkg::MASK_LOW_CAL))
    u_ofs_low (.ref_clk(ref_clk), .srst(srst), .write_en(do_write & hit_ofs_low),
               .write_data(writedata[15:0]), .lane_en(byteenable[1:0]), .value(ofs_low));
  masked_reg16 #(.RESET_VALUE(chcal_pkg::RST_GAIN_HIGH), .WRITE_MASK(chcal_pkg::MASK_FULL))
    u_gain_high (.ref_clk(ref_clk), .srst(srst), .write_en(do_write & hit_gain_high),
                 .write_data(writedata[15:0]), .lane_en(byteenable[1:0]), .value(gain_high));
  masked_reg16 #(.RESET_VALUE(chcal_pkg::RST_GAIN_LOW), .WRITE_MASK(chcal_pkg::MASK_LOW_CAL))
    u_gain_low (.ref_clk(ref_clk), .srst(srst), .write_en(do_write & hit_gain_low),
                .write_data(writedata[15:0]), .lane_en(byteenable[1:0]), .value(gain_low));
  masked_reg16 #(.RESET_VALUE(chcal_pkg::RST_SETUP), .WRITE_MASK(chcal_pkg::MASK_SETUP))
    u_setup4 (.ref_clk(ref_clk), .srst(srst), .write_en(do_write & hit_setup4),
              .write_data(writedata[15:0]), .lane_en(byteenable[1:0]), .value(setup4));

  //****************************************************************************
  // Read path and answer
  //****************************************************************************
  always_comb begin
    read_mux = 16'h0000;
    case (1'b1)
      hit_setup3:    read_mux = setup3;
      hit_ofs_high:  read_mux = ofs_high;
      hit_ofs_low:   read_mux = ofs_low;
      hit_gain_high: read_mux = gain_high;
      hit_gain_low:  read_mux = gain_low;
      hit_setup4:    read_mux = setup4;
      default:       read_mux = 16'h0000;
    endcase
  end

  // Answer is registered so every bus output comes from a flip-flop
  always_comb begin
    next_busy        = access;
    next_waitrequest = ~access;
    next_readdata    = 32'h0000_0000;
    next_response    = 2'h0;
    if (access & read) begin
      next_readdata = {16'h0000, read_mux};
    end
    if (access & ~hit_any) begin
      next_response = 2'h2; // Unmapped word: SLVERR, write dropped
    end
    if (busy) begin
      next_readdata = readdata;
      next_response = response;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy        <= 1'b0;
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
      response    <= 2'h0;
    end else begin
      busy        <= next_busy;
      waitrequest <= next_waitrequest;
      readdata    <= next_readdata;
      response    <= next_response;
    end
  end

  //****************************************************************************
  // Field outputs to the datapath, registered
  //****************************************************************************
  logic [9:0]  next_ph3;
  logic [9:0]  next_ph4;
  logic [23:0] next_ofs;
  logic [23:0] next_gain;

  always_comb begin
    next_ph3  = setup3[chcal_pkg::PHASE_HI:chcal_pkg::PHASE_LO];
    next_ph4  = setup4[chcal_pkg::PHASE_HI:chcal_pkg::PHASE_LO];
    // Offset is two's complement; bit 23 is the sign
    next_ofs  = {ofs_high, ofs_low[chcal_pkg::CAL_LOW_HI:chcal_pkg::CAL_LOW_LO]};
    // Gain is unsigned, 24'h800000 means exactly one
    next_gain = {gain_high, gain_low[chcal_pkg::CAL_LOW_HI:chcal_pkg::CAL_LOW_LO]};
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      // Outputs start from the words' own reset values so the lag never shows a stale field
      ch3_phase_delay      <= chcal_pkg::RST_SETUP[chcal_pkg::PHASE_HI:chcal_pkg::PHASE_LO];
      ch3_dc_filter_bypass <= chcal_pkg::RST_SETUP[chcal_pkg::BYPASS_BIT];
      ch3_input_select     <= chcal_pkg::RST_SETUP[chcal_pkg::SEL_HI:chcal_pkg::SEL_LO];
      ch3_offset_value     <= {chcal_pkg::RST_OFS_HIGH,
        chcal_pkg::RST_OFS_LOW[chcal_pkg::CAL_LOW_HI:chcal_pkg::CAL_LOW_LO]};
      ch3_gain_value       <= {chcal_pkg::RST_GAIN_HIGH,
        chcal_pkg::RST_GAIN_LOW[chcal_pkg::CAL_LOW_HI:chcal_pkg::CAL_LOW_LO]};
      ch4_phase_delay      <= chcal_pkg::RST_SETUP[chcal_pkg::PHASE_HI:chcal_pkg::PHASE_LO];
      ch4_dc_filter_bypass <= chcal_pkg::RST_SETUP[chcal_pkg::BYPASS_BIT];
      ch4_input_select     <= chcal_pkg::RST_SETUP[chcal_pkg::SEL_HI:chcal_pkg::SEL_LO];
    end else begin
      ch3_phase_delay      <= next_ph3;
      ch3_dc_filter_bypass <= setup3[chcal_pkg::BYPASS_BIT];
      ch3_input_select     <= setup3[chcal_pkg::SEL_HI:chcal_pkg::SEL_LO];
      ch3_offset_value     <= next_ofs;
      ch3_gain_value       <= next_gain;
      ch4_phase_delay      <= next_ph4;
      ch4_dc_filter_bypass <= setup4[chcal_pkg::BYPASS_BIT];
      ch4_input_select     <= setup4[chcal_pkg::SEL_HI:chcal_pkg::SEL_LO];
    end
  end

  //****************************************************************************
  // Checks
  //****************************************************************************
  // Writes to the two setup words, seen at the edge where they land
  sequence s_write_setup3;
    write && !waitrequest && hit_setup3;
  endsequence

  sequence s_write_setup4;
    write && !waitrequest && hit_setup4;
  endsequence

  // A fresh request taken by an idle slave, then its single answer cycle
  sequence s_bus_request;
    (read || write) && waitrequest && !busy;
  endsequence

  sequence s_bus_answer;
    !waitrequest ##1 waitrequest;
  endsequence

  // Reserved bits can only read zero if no write ever reaches them
  a_setup_reserved: assert property (@(posedge ref_clk) disable iff (srst)
    setup3[5:3] == 3'h0 && setup4[5:3] == 3'h0)
    else $error("reserved setup bits not zero");
  a_low_reserved: assert property (@(posedge ref_clk) disable iff (srst)
    ofs_low[7:0] == 8'h00 && gain_low[7:0] == 8'h00)
    else $error("reserved calibration bits not zero");

  // Field outputs follow a setup write one edge after it lands, seen sampled at the edge after that
  a_phase_follow: assert property (@(posedge ref_clk) disable iff (srst)
    (s_write_setup3 and (byteenable[1:0] == 2'h3)) |-> ##2
      ch3_phase_delay == $past(writedata[15:6], 2))
    else $error("phase delay not updated");
  a_bypass_follow: assert property (@(posedge ref_clk) disable iff (srst)
    (s_write_setup3 and byteenable[0]) |-> ##2
      ch3_dc_filter_bypass == $past(writedata[2], 2))
    else $error("bypass not updated");
  a_select_follow: assert property (@(posedge ref_clk) disable iff (srst)
    (s_write_setup3 and byteenable[0]) |-> ##2
      ch3_input_select == $past(writedata[1:0], 2))
    else $error("input select not updated");
  a_next_follow: assert property (@(posedge ref_clk) disable iff (srst)
    (s_write_setup4 and (byteenable[1:0] == 2'h3)) |-> ##2
      ch4_phase_delay == $past(writedata[15:6], 2))
    else $error("next channel phase delay not updated");
  a_setup_store: assert property (@(posedge ref_clk) disable iff (srst)
    (s_write_setup3 and (byteenable[1:0] == 2'h3)) |=>
      setup3 == ($past(writedata[15:0]) & chcal_pkg::MASK_SETUP))
    else $error("setup write not stored");

  // Full-word calibration writes land at the answer edge
  a_offset_store: assert property (@(posedge ref_clk) disable iff (srst)
    write && !waitrequest && hit_ofs_high && byteenable[1:0] == 2'h3 |=>
      ofs_high == $past(writedata[15:0]))
    else $error("offset high write not stored");
  a_gain_store: assert property (@(posedge ref_clk) disable iff (srst)
    write && !waitrequest && hit_gain_high && byteenable[1:0] == 2'h3 |=>
      gain_high == $past(writedata[15:0]))
    else $error("gain high write not stored");
  a_offset_join: assert property (@(posedge ref_clk) disable iff (srst)
    ##1 ch3_offset_value == {$past(ofs_high), $past(ofs_low[15:8])})
    else $error("offset assembly wrong");
  a_gain_join: assert property (@(posedge ref_clk) disable iff (srst)
    ##1 ch3_gain_value == {$past(gain_high), $past(gain_low[15:8])})
    else $error("gain assembly wrong");
  a_gain_reset: assert property (@(posedge ref_clk)
    srst |=> gain_high == 16'h8000 && ofs_high == 16'h0000 && setup3 == 16'h0000)
    else $error("reset values wrong");

  // One wait cycle per access; unmapped words answer with an error
  a_answer_time: assert property (@(posedge ref_clk) disable iff (srst)
    s_bus_request |=> s_bus_answer)
    else $error("answer timing wrong");
  a_unmapped_error: assert property (@(posedge ref_clk) disable iff (srst)
    (read || write) && !waitrequest && !hit_any |-> response == 2'h2)
    else $error("unmapped access not refused");
  a_mapped_okay: assert property (@(posedge ref_clk) disable iff (srst)
    (read || write) && !waitrequest && hit_any |-> response == 2'h0)
    else $error("mapped access refused");
  a_upper_zero: assert property (@(posedge ref_clk) disable iff (srst)
    read && !waitrequest |-> readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");

endmodule

`default_nettype wire

// ---- channel_cal_config_regs_tb.sv ----
// Self-checking bench for the channel 3 configuration and calibration registers
`default_nettype none

module channel_cal_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  //****************************************************************************
  // Signals
  //****************************************************************************
  logic        ref_clk;
  logic        srst;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [1:0]  response;
  logic [9:0]  ch3_phase_delay;
  logic        ch3_dc_filter_bypass;
  logic [1:0]  ch3_input_select;
  logic [23:0] ch3_offset_value;
  logic [23:0] ch3_gain_value;
  logic [9:0]  ch4_phase_delay;
  logic        ch4_dc_filter_bypass;
  logic [1:0]  ch4_input_select;
  logic [31:0] rd;
  logic [1:0]  rsp;
  int          num_errors;
  int          checks_done;
  int          cycles;

  channel_cal_config_regs uut (
    .ref_clk              (ref_clk),
    .srst                 (srst),
    .address              (address),
    .read                 (read),
    .write                (write),
    .writedata            (writedata),
    .byteenable           (byteenable),
    .readdata             (readdata),
    .waitrequest          (waitrequest),
    .response             (response),
    .ch3_phase_delay      (ch3_phase_delay),
    .ch3_dc_filter_bypass (ch3_dc_filter_bypass),
    .ch3_input_select     (ch3_input_select),
    .ch3_offset_value     (ch3_offset_value),
    .ch3_gain_value       (ch3_gain_value),
    .ch4_phase_delay      (ch4_phase_delay),
    .ch4_dc_filter_bypass (ch4_dc_filter_bypass),
    .ch4_input_select     (ch4_input_select)
  );

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // Hang guard; the full run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      test_done();
    end
  end

  //****************************************************************************
  // Shared tasks
  //****************************************************************************
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [15:0] data,
                     input logic [3:0] be);
    int n = 0;
    @(posedge ref_clk);
    address <= addr;
    writedata <= {16'h0000, data};
    byteenable <= be;
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0);
    check(32'(n), 32'h00000002);
    rd = readdata;
    rsp = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [15:0] exp, input logic [1:0] er);
    bus(1'b0, addr, 16'h0000, 4'h0);
    check(rd, {16'h0000, exp});
    check({30'h0, rsp}, {30'h0, er});
  endtask

  //****************************************************************************
  // Scenarios
  //****************************************************************************
  task automatic reset_values();
    rd_chk(8'h60, 16'h0000, 2'h0);
    rd_chk(8'h64, 16'h0000, 2'h0);
    rd_chk(8'h68, 16'h0000, 2'h0);
    rd_chk(8'h6C, 16'h8000, 2'h0);
    rd_chk(8'h70, 16'h0000, 2'h0);
    rd_chk(8'h74, 16'h0000, 2'h0);
    check({8'h00, ch3_gain_value}, 32'h00800000);
    check({8'h00, ch3_offset_value}, 32'h00000000);
    check({19'h0, ch3_phase_delay, ch3_dc_filter_bypass, ch3_input_select}, 32'h00000000);
    check({19'h0, ch4_phase_delay, ch4_dc_filter_bypass, ch4_input_select}, 32'h00000000);
  endtask

  // Every input source code, negative phase values, reserved bits 5:3 written high
  task automatic setup_fields();
    logic [15:0] d;
    for (int s = 0; s < 4; s++) begin
      d = {10'h201 + 10'(s), 3'b111, s[0], s[1:0]};
      bus(1'b1, 8'h60, d, 4'h3);
      rd_chk(8'h60, d & 16'hFFC7, 2'h0);
      check({22'h0, ch3_phase_delay}, {22'h0, d[15:6]});
      check({31'h0, ch3_dc_filter_bypass}, {31'h0, s[0]});
      check({30'h0, ch3_input_select}, 32'(s));
    end
  endtask

  // Calibration halves, reserved low bytes and a single-lane write
  task automatic cal_values();
    bus(1'b1, 8'h64, 16'h8123, 4'h3);
    bus(1'b1, 8'h68, 16'hA5FF, 4'h3);
    bus(1'b1, 8'h6C, 16'hFFFF, 4'h3);
    bus(1'b1, 8'h70, 16'h7E5A, 4'h3);
    rd_chk(8'h64, 16'h8123, 2'h0);
    rd_chk(8'h68, 16'hA500, 2'h0);
    rd_chk(8'h6C, 16'hFFFF, 2'h0);
    rd_chk(8'h70, 16'h7E00, 2'h0);
    check({8'h00, ch3_gain_value}, 32'h00FFFF7E);
    bus(1'b1, 8'h64, 16'hEECC, 4'h1);
    rd_chk(8'h64, 16'h81CC, 2'h0);
    check({8'h00, ch3_offset_value}, 32'h0081CCA5);
  endtask

  // Next channel setup and refused accesses outside the map
  task automatic ch4_and_unmapped();
    bus(1'b1, 8'h74, 16'hFFFF, 4'h3);
    rd_chk(8'h74, 16'hFFC7, 2'h0);
    check({19'h0, ch4_phase_delay, ch4_dc_filter_bypass, ch4_input_select},
          32'h00001FFF);
    bus(1'b1, 8'h78, 16'h1234, 4'h3);
    check({30'h0, rsp}, 32'h00000002);
    rd_chk(8'h78, 16'h0000, 2'h2);
    rd_chk(8'h5C, 16'h0000, 2'h2);
    rd_chk(8'h60, 16'h8107, 2'h0);
  endtask

  //****************************************************************************
  // Main sequence
  //****************************************************************************
  initial begin
    ref_clk = 1'b0;
    srst = 1'b1;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'h0;
    num_errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    reset_values();
    setup_fields();
    cal_values();
    ch4_and_unmapped();
    // Second reset in mid-run must restore every default
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    reset_values();
    test_done();
  end

endmodule

`default_nettype wire

// ---- chcal_pkg.sv ----
// Constants for the channel 3 configuration and calibration register set
//****************************************************************************
// Overview of operation
// - Setup bits 15:6 hold signed phase delay
// - Setup bit 2 bypasses DC filter
// - Setup bits 1:0 choose converter input source
// - Offset high register holds offset bits 23:8
// - Offset low bits 15:8 hold bits 7:0
// - Assembled offset is signed two's complement
// - Gain high register holds gain bits 23:8
// - Gain low bits 15:8 hold bits 7:0
// - Gain is unsigned fraction below two
// - Offset high at 19h, reset 0000h
// - Offset low at 1Ah, reset 0000h
// - Gain high at 1Bh, reset 8000h
// - Gain low at 1Ch, reset 0000h
// - Next channel setup at 1Dh, reset 0000h
// - This channel setup at 18h, reset 0000h
//****************************************************************************
`default_nettype none

package chcal_pkg;

  //****************************************************************************
  // Register indices; byte address is four times the index
  //****************************************************************************
  localparam logic [7:0] IDX_CH3_SETUP    = 8'h18;
  localparam logic [7:0] IDX_CH3_OFS_HIGH = 8'h19;
  localparam logic [7:0] IDX_CH3_OFS_LOW  = 8'h1A;
  localparam logic [7:0] IDX_CH3_GAIN_HIGH = 8'h1B;
  localparam logic [7:0] IDX_CH3_GAIN_LOW = 8'h1C;
  localparam logic [7:0] IDX_CH4_SETUP    = 8'h1D;

  //****************************************************************************
  // Reset values
  //****************************************************************************
  localparam logic [15:0] RST_SETUP     = 16'h0000;
  localparam logic [15:0] RST_OFS_HIGH  = 16'h0000;
  localparam logic [15:0] RST_OFS_LOW   = 16'h0000;
  localparam logic [15:0] RST_GAIN_HIGH = 16'h8000;
  localparam logic [15:0] RST_GAIN_LOW  = 16'h0000;

  //****************************************************************************
  // Writable bit masks; clear bits are reserved and read zero
  //****************************************************************************
  localparam logic [15:0] MASK_SETUP   = 16'hFFC7;
  localparam logic [15:0] MASK_FULL    = 16'hFFFF;
  localparam logic [15:0] MASK_LOW_CAL = 16'hFF00;

  //****************************************************************************
  // Field positions
  //****************************************************************************
  localparam int PHASE_HI  = 15;
  localparam int PHASE_LO  = 6;
  localparam int BYPASS_BIT = 2;
  localparam int SEL_HI    = 1;
  localparam int SEL_LO    = 0;
  localparam int CAL_LOW_HI = 15;
  localparam int CAL_LOW_LO = 8;

  // Input source encodings
  typedef enum logic [1:0] {
    SRC_PINS    = 2'h0,
    SRC_SHORTED = 2'h1,
    SRC_POS_DC  = 2'h2,
    SRC_NEG_DC  = 2'h3
  } input_src_t;

endpackage

`default_nettype wire
